// ==== src/prstat_defines.svh ====
// Constants for the maintenance-port command interpreter.
// Assumes inclusion by bare name from package and modules.
`ifndef PRSTAT_DEFINES_SVH
`define PRSTAT_DEFINES_SVH
// =========================================
// Message layout
`define PRS_MSG_BYTES 8
`define PRS_MSG_TYPE 8'h02
`define PRS_OP_PORT 8'hFF
`define PRS_OPD_CLOSE 8'h01
`define PRS_OPD_OPEN 8'h00
`define PRS_UDP_PORT 16'h1E5F
// =========================================
// General status codes
`define PRS_ST_SUCCESS 8'h00
`define PRS_ST_CONN_FAIL 8'h01
`define PRS_ST_NO_RESOURCE 8'h02
`define PRS_ST_OLD_PARAM 8'h03
`define PRS_ST_PATH_SEG 8'h04
`define PRS_ST_PATH_DEST 8'h05
`define PRS_ST_PARTIAL 8'h06
`define PRS_ST_CONN_LOST 8'h07
`define PRS_ST_NO_SERVICE 8'h08
`define PRS_ST_BAD_ATTR 8'h09
`define PRS_ST_ATTR_LIST 8'h0A
`define PRS_ST_ALREADY 8'h0B
`define PRS_ST_OBJ_STATE 8'h0C
`define PRS_ST_EXISTS 8'h0D
`define PRS_ST_NOT_SETTABLE 8'h0E
`define PRS_ST_PRIVILEGE 8'h0F
`define PRS_ST_DEV_STATE 8'h10
`define PRS_ST_REPLY_LARGE 8'h11
`define PRS_ST_FRAGMENT 8'h12
`define PRS_ST_TOO_LITTLE 8'h13
`define PRS_ST_NO_ATTR 8'h14
`define PRS_ST_TOO_MUCH 8'h15
`define PRS_ST_NO_OBJECT 8'h16
`define PRS_ST_NO_FRAG_SEQ 8'h17
`define PRS_ST_NO_STORED 8'h18
`define PRS_ST_STORE_FAIL 8'h19
`define PRS_ST_INVALID_PARAM 8'h20
`endif

// ==== src/prstat_pkg.sv ====
// Types shared by the maintenance-port interpreter modules.
// Assumes the defines header sits on the include path.
`include "prstat_defines.svh"
package prstat_pkg;
   // =========================================
   // Fault conditions, one-hot in a vector, lowest index wins except path seg and dest, which rank second and third
   typedef enum logic [4:0]
   {
      PRS_F_CONN_FAIL, PRS_F_NO_RESOURCE, PRS_F_BAD_PARAM, PRS_F_PATH_SEG,
      PRS_F_PATH_DEST, PRS_F_PARTIAL, PRS_F_CONN_LOST, PRS_F_NO_SERVICE,
      PRS_F_BAD_ATTR, PRS_F_ATTR_LIST, PRS_F_ALREADY, PRS_F_OBJ_STATE,
      PRS_F_EXISTS, PRS_F_NOT_SETTABLE, PRS_F_PRIVILEGE, PRS_F_DEV_STATE,
      PRS_F_REPLY_LARGE, PRS_F_FRAGMENT, PRS_F_TOO_LITTLE, PRS_F_NO_ATTR,
      PRS_F_TOO_MUCH, PRS_F_NO_OBJECT, PRS_F_NO_FRAG_SEQ, PRS_F_NO_STORED,
      PRS_F_STORE_FAIL
   } prs_fault_e;
   typedef logic [24:0] prs_faults_t;
   typedef logic [7:0] prs_byte_t;
   typedef logic [15:0] prs_status_t;
endpackage

// ==== src/prs_status_encoder.sv ====
// Encodes a vector of fault flags into a general status code.
// Assumes flags are stable while the caller samples the result.
`timescale 1ns/10ps
`include "prstat_defines.svh"
module prs_status_encoder
(
   // Fault flags, index per prs_fault_e
   input wire prstat_pkg::prs_faults_t faults,
   // Encoded general status
   output logic [7:0] general
);
   import prstat_pkg::*;

   // Fixed priority: path errors stop processing, so they rank near the top
   always_comb
   begin
      general = `PRS_ST_SUCCESS;
      if (faults[PRS_F_CONN_FAIL]) general = `PRS_ST_CONN_FAIL;
      else if (faults[PRS_F_PATH_SEG]) general = `PRS_ST_PATH_SEG;
      else if (faults[PRS_F_PATH_DEST]) general = `PRS_ST_PATH_DEST;
      else if (faults[PRS_F_NO_RESOURCE]) general = `PRS_ST_NO_RESOURCE;
      else if (faults[PRS_F_BAD_PARAM]) general = `PRS_ST_INVALID_PARAM;
      else if (faults[PRS_F_PARTIAL]) general = `PRS_ST_PARTIAL;
      else if (faults[PRS_F_CONN_LOST]) general = `PRS_ST_CONN_LOST;
      else if (faults[PRS_F_NO_SERVICE]) general = `PRS_ST_NO_SERVICE;
      else if (faults[PRS_F_BAD_ATTR]) general = `PRS_ST_BAD_ATTR;
      else if (faults[PRS_F_ATTR_LIST]) general = `PRS_ST_ATTR_LIST;
      else if (faults[PRS_F_ALREADY]) general = `PRS_ST_ALREADY;
      else if (faults[PRS_F_OBJ_STATE]) general = `PRS_ST_OBJ_STATE;
      else if (faults[PRS_F_EXISTS]) general = `PRS_ST_EXISTS;
      else if (faults[PRS_F_NOT_SETTABLE]) general = `PRS_ST_NOT_SETTABLE;
      else if (faults[PRS_F_PRIVILEGE]) general = `PRS_ST_PRIVILEGE;
      else if (faults[PRS_F_DEV_STATE]) general = `PRS_ST_DEV_STATE;
      else if (faults[PRS_F_REPLY_LARGE]) general = `PRS_ST_REPLY_LARGE;
      else if (faults[PRS_F_FRAGMENT]) general = `PRS_ST_FRAGMENT;
      else if (faults[PRS_F_TOO_LITTLE]) general = `PRS_ST_TOO_LITTLE;
      else if (faults[PRS_F_NO_ATTR]) general = `PRS_ST_NO_ATTR;
      else if (faults[PRS_F_TOO_MUCH]) general = `PRS_ST_TOO_MUCH;
      else if (faults[PRS_F_NO_OBJECT]) general = `PRS_ST_NO_OBJECT;
      else if (faults[PRS_F_NO_FRAG_SEQ]) general = `PRS_ST_NO_FRAG_SEQ;
      else if (faults[PRS_F_NO_STORED]) general = `PRS_ST_NO_STORED;
      else if (faults[PRS_F_STORE_FAIL]) general = `PRS_ST_STORE_FAIL;
   end
endmodule

// ==== src/prs_port_ctrl.sv ====
// Maintenance-port command interpreter: takes an eight-byte command,
// runs the port close/reopen opcode and answers with eight bytes.
// Assumes byte strobes come from logic on clk; faults are same-domain levels.
`timescale 1ns/10ps
`include "prstat_defines.svh"
// Behaviour
// - Answer echoes type, opcode, operand; status in bytes four and five.
// - Opcode FF operand one closes and resets maintenance port 7775.
// - Opcode FF operand zero after reset reopens port for new host.
// - Error answers carry general code and an extended code field.
// - Successful service reports status 00.
// - Codes 01, 02, 06, 07 for connection, resource, partial, lost.
// - Invalid parameter reports 0x20, never the older 03.
// - Path segment not understood reports 04; path processing stops.
// - Unknown class, instance or element reports 05; processing stops.
// - Codes 08, 14, 16 for service, attribute, object not present.
// - Code 09 for bad attribute data, 0E for unsettable attribute.
// - Code 0A when a list attribute has non-zero status.
// - Codes 0B, 0C, 10 for already-in-state, object and device conflicts.
// - Code 0D when creating an instance that already exists.
// - Code 0F when a privilege check fails.
// - Code 11 when reply data exceeds response space.
// - Code 12 when an operation splits a primitive value.
// - Code 13 for too little data, 15 for too much.
// - Code 17 for continuation with no fragmentation sequence active.
// - Code 18 for restore of unsaved data, 19 for failed save.
// - Only one host holds the port until reset and reopen.
module prs_port_ctrl
#(
   parameter int MSG_BYTES = `PRS_MSG_BYTES
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Command byte stream
   input wire logic cmdValid,
   input wire prstat_pkg::prs_byte_t cmdByte,
   input wire logic cmdLast,
   // Faults reported by the addressed object, sampled at the last byte
   input wire prstat_pkg::prs_faults_t faults,
   input wire prstat_pkg::prs_byte_t extendedCode,
   // Host connection attempts
   input wire logic connectReq,
   // Response byte stream
   output logic rspValid,
   output prstat_pkg::prs_byte_t rspByte,
   output logic rspLast,
   output prstat_pkg::prs_byte_t rspExtended,
   // Port state
   output logic portOpen,
   output logic hostHeld,
   output logic connectAccept,
   output logic connectRefuse,
   output logic [15:0] portNumber
);
   import prstat_pkg::*;

   // Elaboration check: the byte counter and answer layout serve eight bytes only
   if (MSG_BYTES != `PRS_MSG_BYTES)
   begin : gBadSize
      $error("MSG_BYTES must be eight");
   end

   typedef enum logic [1:0] {PRS_IDLE, PRS_DROP, PRS_ANSWER} prs_state_e;

   prs_state_e state_q;
   prs_byte_t cmd_q [MSG_BYTES];
   logic [2:0] idx_q;
   logic portOpen_q;
   logic hostHeld_q;
   logic [7:0] general;
   prs_status_t status_q;
   logic badFrame;
   logic isPortOp;

   // =========================================
   // Status encoding
   // code table lookup
   prs_status_encoder u_enc
   (
      .faults(faults),
      .general(general)
   );

   assign badFrame = (cmd_q[0] != 8'h00) || (cmd_q[1] != `PRS_MSG_TYPE);
   assign isPortOp = (cmd_q[2] == `PRS_OP_PORT);

   // =========================================
   // Command capture and answer sequencing
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         state_q <= PRS_IDLE;
         idx_q <= 3'h0;
      end
      else
      begin
         unique case (state_q)
            PRS_IDLE:
            begin
               if (cmdValid)
               begin
                  idx_q <= idx_q + 3'h1;
                  if (cmdLast)
                  begin
                     idx_q <= 3'h0;
                     state_q <= (idx_q == 3'h7) ? PRS_ANSWER : PRS_IDLE;
                  end
                  else if (idx_q == 3'h7)
                     state_q <= PRS_DROP;
               end
            end
            PRS_DROP:
            begin
               // Overlong frame: discard to its end
               if (cmdValid && cmdLast)
                  state_q <= PRS_IDLE;
            end
            PRS_ANSWER:
            begin
               idx_q <= idx_q + 3'h1;
               if (idx_q == 3'h7)
               begin
                  idx_q <= 3'h0;
                  state_q <= PRS_IDLE;
               end
            end
            default: state_q <= PRS_IDLE;
         endcase
      end
   end

   // Command byte store
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         for (int i = 0; i < MSG_BYTES; i++)
            cmd_q[i] <= 8'h00;
      end
      else if (state_q == PRS_IDLE && cmdValid)
         cmd_q[idx_q] <= cmdByte;
   end

   // =========================================
   // Status selection at end of a good frame
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         status_q <= 16'h0000;
      else if (state_q == PRS_IDLE && cmdValid && cmdLast && idx_q == 3'h7)
      begin
         status_q <= {8'h00, general};
      end
      else if (state_q == PRS_ANSWER && idx_q == 3'h0)
      begin
         if (badFrame)
            status_q <= {8'h00, `PRS_ST_INVALID_PARAM};
         else if (!isPortOp && status_q == 16'h0000)
            status_q <= {8'h00, `PRS_ST_NO_SERVICE};
         else if (isPortOp && cmd_q[3] != `PRS_OPD_CLOSE && cmd_q[3] != `PRS_OPD_OPEN)
            status_q <= {8'h00, `PRS_ST_INVALID_PARAM};
         else if (isPortOp && cmd_q[3] == `PRS_OPD_OPEN && (portOpen_q || hostHeld_q))
            status_q <= {8'h00, `PRS_ST_ALREADY};
      end
   end

   // =========================================
   // Maintenance port state
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         portOpen_q <= 1'b1;
         hostHeld_q <= 1'b0;
      end
      else if (state_q == PRS_ANSWER && idx_q == 3'h1 && status_q == 16'h0000 && isPortOp)
      begin
         if (cmd_q[3] == `PRS_OPD_CLOSE)
         begin
            portOpen_q <= 1'b0;
            hostHeld_q <= 1'b0;
         end
         else if (cmd_q[3] == `PRS_OPD_OPEN)
            portOpen_q <= 1'b1;
      end
      else if (connectReq && portOpen_q && !hostHeld_q)
         hostHeld_q <= 1'b1;
   end

   // Connection answer pulses
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         connectAccept <= 1'b0;
         connectRefuse <= 1'b0;
      end
      else
      begin
         connectAccept <= connectReq && portOpen_q && !hostHeld_q;
         connectRefuse <= connectReq && !(portOpen_q && !hostHeld_q);
      end
   end

   // =========================================
   // Response byte stream
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         rspValid <= 1'b0;
         rspByte <= 8'h00;
         rspLast <= 1'b0;
         rspExtended <= 8'h00;
      end
      else
      begin
         rspValid <= (state_q == PRS_ANSWER);
         rspLast <= (state_q == PRS_ANSWER) && (idx_q == 3'h7);
         rspByte <= 8'h00;
         if (state_q == PRS_IDLE && cmdValid && cmdLast)
            rspExtended <= (general == `PRS_ST_SUCCESS) ? 8'h00 : extendedCode;
         if (state_q == PRS_ANSWER)
         begin
            unique case (idx_q)
               3'h1: rspByte <= cmd_q[1];
               3'h2: rspByte <= cmd_q[2];
               3'h3: rspByte <= cmd_q[3];
               3'h4: rspByte <= status_q[15:8];
               3'h5: rspByte <= status_q[7:0];
               default: rspByte <= 8'h00;
            endcase
         end
      end
   end

   assign portOpen = portOpen_q;
   assign hostHeld = hostHeld_q;

   // Fixed port number output
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         portNumber <= `PRS_UDP_PORT;
      else
         portNumber <= `PRS_UDP_PORT;
   end

   // =========================================
   // Checks
   AST_CLOSE_DROPS: assert property (@(posedge clk) disable iff (!reset_n)
      (state_q == PRS_ANSWER && idx_q == 3'h1 && status_q == 16'h0000 && isPortOp
       && cmd_q[3] == `PRS_OPD_CLOSE) |=> (!portOpen && !hostHeld))
      else $error("close did not drop port");
   AST_REOPEN: assert property (@(posedge clk) disable iff (!reset_n)
      (state_q == PRS_ANSWER && idx_q == 3'h1 && status_q == 16'h0000 && isPortOp
       && cmd_q[3] == `PRS_OPD_OPEN) |=> portOpen)
      else $error("reopen did not open port");
   AST_ONE_HOST: assert property (@(posedge clk) disable iff (!reset_n)
      hostHeld && connectReq |=> connectRefuse && !connectAccept)
      else $error("second host accepted");
   AST_ANSWER_LEN: assert property (@(posedge clk) disable iff (!reset_n)
      $rose(rspValid) |-> rspValid [*8] ##0 rspLast)
      else $error("answer not eight bytes");
   AST_TYPE_ECHO: assert property (@(posedge clk) disable iff (!reset_n)
      $rose(rspValid) |=> rspByte == cmd_q[1])
      else $error("type byte not echoed");
   AST_NO_OLD_CODE: assert property (@(posedge clk) disable iff (!reset_n)
      status_q[7:0] != `PRS_ST_OLD_PARAM)
      else $error("discouraged code 03 used");
   AST_SUCCESS: assert property (@(posedge clk) disable iff (!reset_n)
      faults == '0 |-> general == `PRS_ST_SUCCESS)
      else $error("success not zero");
   AST_PATH_FIRST: assert property (@(posedge clk) disable iff (!reset_n)
      faults[PRS_F_PATH_SEG] && !faults[PRS_F_CONN_FAIL] |-> general == `PRS_ST_PATH_SEG)
      else $error("path segment error not reported");
   AST_OPCODE_ECHO: assert property (@(posedge clk) disable iff (!reset_n)
      $rose(rspValid) |=> ##1 rspByte == cmd_q[2])
      else $error("opcode byte not echoed");
   AST_TAIL_ZERO: assert property (@(posedge clk) disable iff (!reset_n)
      rspLast |-> rspByte == 8'h00)
      else $error("last answer byte not zero");
   AST_ACCEPT_FREE: assert property (@(posedge clk) disable iff (!reset_n)
      connectReq && portOpen && !hostHeld |=> connectAccept && !connectRefuse)
      else $error("free port refused a host");
   AST_REFUSE_CLOSED: assert property (@(posedge clk) disable iff (!reset_n)
      connectReq && !portOpen |=> connectRefuse && !connectAccept)
      else $error("closed port accepted a host");
   COV_ANSWER: cover property (@(posedge clk) disable iff (!reset_n) rspLast);
   COV_CLOSE: cover property (@(posedge clk) disable iff (!reset_n) $fell(portOpen));
   COV_OPEN: cover property (@(posedge clk) disable iff (!reset_n) $rose(portOpen));
   COV_REFUSE: cover property (@(posedge clk) disable iff (!reset_n) connectRefuse);
endmodule

// ==== tb/prs_host_model.sv ====
// Host model that sends maintenance command frames of nBytes bytes as a byte stream.
// Assumes the bench pulses go for one cycle and waits for busy to drop.
`timescale 1ns/10ps
module prs_host_model
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Request from the bench
   input wire logic go,
   input wire prstat_pkg::prs_byte_t op,
   input wire prstat_pkg::prs_byte_t opd,
   input wire logic [3:0] nBytes,
   // Command byte stream
   output logic cmdValid,
   output prstat_pkg::prs_byte_t cmdByte,
   output logic cmdLast,
   output logic busy
);
   import prstat_pkg::*;
   logic [3:0] idx;
   prs_byte_t frameByte;

   // =========================================
   // Frame content
   // fixed frame layout
   always_comb
   begin
      case (idx)
         4'h1: frameByte = 8'h02;
         4'h2: frameByte = op;
         4'h3: frameByte = opd;
         default: frameByte = 8'h00;
      endcase
   end

   // =========================================
   // Byte sequencer; data line toggles while idle
   // one message each
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         idx <= 4'h0;
         busy <= 1'b0;
         cmdValid <= 1'b0;
         cmdByte <= 8'h00;
         cmdLast <= 1'b0;
      end
      else if (go && !busy)
      begin
         busy <= 1'b1;
         idx <= 4'h0;
      end
      else if (busy)
      begin
         cmdValid <= 1'b1;
         cmdByte <= frameByte;
         cmdLast <= (idx == nBytes - 4'h1);
         idx <= idx + 4'h1;
         busy <= (idx != nBytes - 4'h1);
      end
      else
      begin
         cmdValid <= 1'b0;
         cmdLast <= 1'b0;
         cmdByte <= ~cmdByte; // Stale data never looks valid
      end
   end
endmodule

// ==== tb/testbench.sv ====
// Self-checking bench for the maintenance-port command interpreter.
// Assumes the design sources and the host model are compiled first.
`timescale 1ns/10ps
module testbench;
   import prstat_pkg::*;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic go = 1'b0;
   prs_byte_t op = 8'h00;
   prs_byte_t opd = 8'h00;
   logic [3:0] nBytes = 4'h8;
   prs_faults_t faults = '0;
   prs_byte_t extendedCode = 8'h00;
   logic connectReq = 1'b0;
   logic cmdValid, cmdLast, busy, rspValid, rspLast, portOpen, hostHeld;
   logic connectAccept, connectRefuse;
   prs_byte_t cmdByte, rspByte, rspExtended;
   logic [15:0] portNumber;
   int err_count = 0;
   int num_checks = 0;
   int cycles = 0;
   localparam logic [7:0] CODES [25] = '{8'h01, 8'h02, 8'h20, 8'h04, 8'h05, 8'h06, 8'h07,
      8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h0F, 8'h10, 8'h11, 8'h12, 8'h13,
      8'h14, 8'h15, 8'h16, 8'h17, 8'h18, 8'h19};

   // =========================================
   // Clock, instances and timeout
   always #10 clk = ~clk;
   prs_host_model i_prs_host_model (.clk(clk), .reset_n(reset_n), .go(go), .op(op),
      .opd(opd), .nBytes(nBytes), .cmdValid(cmdValid), .cmdByte(cmdByte),
      .cmdLast(cmdLast), .busy(busy));
   prs_port_ctrl i_prs_port_ctrl (.clk(clk), .reset_n(reset_n), .cmdValid(cmdValid),
      .cmdByte(cmdByte), .cmdLast(cmdLast), .faults(faults), .extendedCode(extendedCode),
      .connectReq(connectReq), .rspValid(rspValid), .rspByte(rspByte), .rspLast(rspLast),
      .rspExtended(rspExtended), .portOpen(portOpen), .hostHeld(hostHeld),
      .connectAccept(connectAccept), .connectRefuse(connectRefuse),
      .portNumber(portNumber));
   // Cut a hang short
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         err_count++;
         final_report();
      end
   end

   // =========================================
   // Shared tasks
   task automatic final_report();
      if (err_count == 0 && num_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Launch one frame of n bytes through the host model
   task automatic send(input prs_byte_t o, input prs_byte_t d, input logic [3:0] n);
      @(posedge clk);
      op <= o;
      opd <= d;
      nBytes <= n;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      @(negedge clk);
      while (busy === 1'b1)
         @(negedge clk);
   endtask
   // Full command and a byte-by-byte check of the answer
   task automatic do_cmd(input prs_byte_t o, input prs_byte_t d, input prs_byte_t st);
      int k;
      prs_byte_t e [8];
      e = '{8'h00, 8'h02, o, d, 8'h00, st, 8'h00, 8'h00};
      send(o, d, 4'h8);
      k = 0;
      while (rspValid !== 1'b1 && k < 20)
      begin
         @(negedge clk);
         k++;
      end
      for (int i = 0; i < 8; i++)
      begin
         chk(rspValid, 16'h1);
         chk(rspByte, e[i]);
         chk(rspLast, 16'(i == 7));
         @(negedge clk);
      end
   endtask
   // One connection attempt by a host
   task automatic conn(input logic acc);
      @(posedge clk);
      connectReq <= 1'b1;
      @(posedge clk);
      connectReq <= 1'b0;
      @(negedge clk);
      chk(connectAccept, acc);
      chk(connectRefuse, !acc);
   endtask

   // =========================================
   // Scenarios
   task automatic t_reset();
      chk(portOpen, 16'h1);
      chk(hostHeld, 16'h0);
      chk(portNumber, 16'h1E5F);
   endtask
   // Close, refuse while closed, reopen, new host
   task automatic t_handover();
      conn(1'b1);
      conn(1'b0);
      chk(hostHeld, 16'h1);
      do_cmd(8'hFF, 8'h01, 8'h00);
      chk(portOpen, 16'h0);
      chk(hostHeld, 16'h0);
      conn(1'b0);
      do_cmd(8'hFF, 8'h00, 8'h00);
      chk(portOpen, 16'h1);
      chk(rspExtended, 16'h0);
      conn(1'b1);
   endtask
   // Reopen while open and a bad operand
   task automatic t_errors();
      do_cmd(8'hFF, 8'h00, 8'h0B);
      do_cmd(8'hFF, 8'h05, 8'h20);
      chk(portOpen, 16'h1);
   endtask
   // Every fault flag alone, then priority cases
   task automatic t_faults();
      for (int i = 0; i < 25; i++)
      begin
         @(posedge clk);
         faults <= 25'h1 << i;
         extendedCode <= 8'(i + 1);
         do_cmd(8'h84, 8'h80, CODES[i]);
         chk(rspExtended, 16'(i + 1));
      end
      @(posedge clk);
      faults <= 25'h1C;
      do_cmd(8'h84, 8'h80, 8'h04);
      @(posedge clk);
      faults <= 25'h30;
      do_cmd(8'h84, 8'h80, 8'h05);
      @(posedge clk);
      faults <= '0;
      do_cmd(8'h84, 8'h80, 8'h08);
   endtask
   // Short and overlong frames are dropped, next frame answers
   task automatic t_short();
      logic seen;
      for (int j = 0; j < 2; j++)
      begin
         seen = 1'b0;
         send(8'h84, 8'h80, (j == 0) ? 4'h5 : 4'h9);
         repeat (16)
         begin
            @(negedge clk);
            seen = seen | rspValid;
         end
         chk(seen, 16'h0);
      end
      do_cmd(8'h84, 8'h80, 8'h08);
   endtask

   // =========================================
   // Main sequence
   initial
   begin
      repeat (16) @(posedge clk);
      reset_n <= 1'b1;
      @(negedge clk);
      t_reset();
      t_handover();
      t_errors();
      t_faults();
      t_short();
      final_report();
   end
endmodule
